// [scr_pkg.sv]
package scr_pkg;

    // ********************************
    // Register indices (byte address is four times the index)
    // ********************************
    localparam logic [9:0] IDX_CONTROL  = 10'h0C8;
    localparam logic [9:0] IDX_MODE     = 10'h0C9;
    localparam logic [9:0] IDX_CAP_LOW  = 10'h0CA;
    localparam logic [9:0] IDX_CAP_HIGH = 10'h0CB;
    localparam logic [9:0] IDX_CNT_LOW  = 10'h0CC;
    localparam logic [9:0] IDX_CNT_HIGH = 10'h0CD;
    localparam logic [9:0] IDX_AUX      = 10'h0CE;

    // ********************************
    // Field positions and reset values
    // ********************************
    localparam int MODE_DOWN_BIT  = 0;
    localparam int MODE_CLKOE_BIT = 1;
    localparam int AUX_SPEED_BIT  = 0;
    localparam int AUX_IRQEN_BIT  = 1;

    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;

    // ********************************
    // Tick periods in core clocks
    // ********************************
    localparam logic [3:0] TICKS_SLOW = 4'hC;
    localparam logic [3:0] TICKS_FAST = 4'h4;
    localparam logic [3:0] TICKS_BAUD = 4'h2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic rollover_flag;
        logic ext_event_flag;
        logic rx_baud_select;
        logic tx_baud_select;
        logic ext_trigger_enable;
        logic run_control;
        logic counter_select;
        logic capture_reload_select;
    } scr_ctrl_t;

    typedef struct packed {
        logic rx_tick;
        logic tx_tick;
    } scr_baud_t;

endpackage : scr_pkg

// [scr_timer.sv]
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// How it works
// - Rollover flag sets on FFFFh to 0000h, or count equals capture when counting down.
// - Rollover flag stays set until software clears it.
// - Rollover flag sets only while both baud select bits are zero.
// - Trigger falling edge sets external flag if trigger enabled and not down counting.
// - Reload with down counting: external flag toggles per rollover, no interrupt.
// - Software clears edge-set external flag; flag set by edge or write interrupts.
// - Receive baud select picks timer 1 or this timer in serial modes 1, 3.
// - Transmit baud select picks timer 1 or this timer in serial modes 1, 3.
// - Either baud select forces baud generation mode at half the clock.
// - Trigger disabled ignores pin edges; enabled outside baud and down counting, edge captures or reloads.
// - Run control starts counting; halted timer keeps both count bytes except on an enabled trigger reload.
// - Counter select zero counts timer ticks by speed; one counts count pin falls outside baud mode.
// - Baud or clock output mode advances once every two clocks.
// - In baud mode capture select is ignored; reload after each overflow.
// - Capture select zero reloads on overflow and, unless down counting, on enabled trigger edge.
// - Capture select one with trigger enabled captures count on trigger edge.
// - Reload mode direction up, or trigger pin level when down counting enabled.
// - Capture bytes receive count on capture and supply reload value.
// - Clock output drives count pin; its rollovers raise no interrupt.
module scr_timer
    import scr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic               clk_en,
    input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [ADDR_W-1:0]  s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               ext_trigger_pin,
    input  wire logic               count_input_pin,
    output logic                    count_pin_o,
    output logic                    count_pin_oe,
    input  wire logic [1:0]         serial_mode,
    input  wire logic               timer1_overflow,
    output scr_pkg::scr_baud_t      baud_ticks,
    output logic                    timer_irq
);
    import scr_pkg::*;

    // ********************************
    // Register state
    // ********************************
    scr_ctrl_t   ctrl_reg;
    logic        down_count_enable_reg;
    logic        clock_out_enable_reg;
    logic        tick_speed_select_reg;
    logic        irq_enable_reg;
    logic [15:0] capture_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [3:0]  pre_reg;
    logic        clk_out_reg;
    logic        pin_oe_reg;

    // ********************************
    // Bus decode
    // ********************************
    logic       wr_fire;
    logic       rd_fire;
    logic [9:0] wr_idx;
    logic [9:0] rd_idx;
    logic       wr_lane;
    logic [7:0] wr_byte;
    logic       ctrl_wr;
    logic       cap_lo_wr;
    logic       cap_hi_wr;
    logic       cnt_lo_wr;
    logic       cnt_hi_wr;
    logic       wr_mapped;
    logic       rd_mapped;
    logic [7:0] rd_byte;

    assign s_axi_awready = clk_en && !s_axi_bvalid && s_axi_awvalid && s_axi_wvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = clk_en && !s_axi_rvalid;
    assign wr_fire       = s_axi_awready;
    assign rd_fire       = s_axi_arready && s_axi_arvalid;
    assign wr_idx        = s_axi_awaddr[11:2];
    assign rd_idx        = s_axi_araddr[11:2];
    assign wr_lane       = wr_fire && s_axi_wstrb[0];
    assign wr_byte       = s_axi_wdata[7:0];
    assign ctrl_wr       = wr_lane && (wr_idx == IDX_CONTROL);
    assign cap_lo_wr     = wr_lane && (wr_idx == IDX_CAP_LOW);
    assign cap_hi_wr     = wr_lane && (wr_idx == IDX_CAP_HIGH);
    assign cnt_lo_wr     = wr_lane && (wr_idx == IDX_CNT_LOW);
    assign cnt_hi_wr     = wr_lane && (wr_idx == IDX_CNT_HIGH);
    assign wr_mapped     = (wr_idx >= IDX_CONTROL) && (wr_idx <= IDX_AUX);
    assign rd_mapped     = (rd_idx >= IDX_CONTROL) && (rd_idx <= IDX_AUX);

    always_comb begin
        case (rd_idx)
            IDX_CONTROL:  rd_byte = ctrl_reg;
            IDX_MODE:     rd_byte = {6'h00, clock_out_enable_reg, down_count_enable_reg};
            IDX_CAP_LOW:  rd_byte = capture_reg[7:0];
            IDX_CAP_HIGH: rd_byte = capture_reg[15:8];
            IDX_CNT_LOW:  rd_byte = count_reg[7:0];
            IDX_CNT_HIGH: rd_byte = count_reg[15:8];
            IDX_AUX:      rd_byte = {6'h00, irq_enable_reg, tick_speed_select_reg};
            default:      rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
                s_axi_rdata  <= {24'h000000, rd_byte};
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ********************************
    // Pin synchronisers
    // ********************************
    // Level moves only when stages two and three agree, filtering one-sample glitches
    logic [2:0] trig_sync;
    logic [2:0] cpin_sync;
    logic       trig_lvl_reg;
    logic       cpin_lvl_reg;
    logic       trig_fall;
    logic       cpin_fall;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_sync    <= 3'h7;
            cpin_sync    <= 3'h7;
            trig_lvl_reg <= 1'b1;
            cpin_lvl_reg <= 1'b1;
        end else if (clk_en) begin
            trig_sync <= {trig_sync[1:0], ext_trigger_pin};
            cpin_sync <= {cpin_sync[1:0], count_input_pin};
            if (trig_sync[1] == trig_sync[2]) begin
                trig_lvl_reg <= trig_sync[2];
            end
            if (cpin_sync[1] == cpin_sync[2]) begin
                cpin_lvl_reg <= cpin_sync[2];
            end
        end
    end

    assign trig_fall = trig_lvl_reg && !trig_sync[2] && (trig_sync[1] == trig_sync[2]);
    assign cpin_fall = cpin_lvl_reg && !cpin_sync[2] && (cpin_sync[1] == cpin_sync[2]);

    // ********************************
    // Mode decode
    // ********************************
    logic       baud_mode;
    logic       clkout_active;
    logic       fast_mode;
    logic       toggle_mode;
    logic       counting_down;
    logic       reload_mode;
    logic [3:0] pre_limit;
    logic       pre_hit;
    logic       tick_evt;
    logic       ovf_evt;
    logic       trig_reload;
    logic       cap_evt;
    logic       ext_set;

    assign baud_mode     = ctrl_reg.rx_baud_select || ctrl_reg.tx_baud_select;
    assign clkout_active = clock_out_enable_reg && !ctrl_reg.counter_select;
    assign fast_mode     = baud_mode || clkout_active;
    assign toggle_mode   = down_count_enable_reg && !ctrl_reg.capture_reload_select
                           && !baud_mode;
    assign counting_down = toggle_mode && !trig_lvl_reg;
    assign reload_mode   = !ctrl_reg.capture_reload_select || fast_mode;

    always_comb begin
        if (fast_mode) begin
            pre_limit = TICKS_BAUD;
        end else if (tick_speed_select_reg) begin
            pre_limit = TICKS_FAST;
        end else begin
            pre_limit = TICKS_SLOW;
        end
    end

    assign pre_hit  = (pre_reg >= pre_limit - 4'h1);
    assign tick_evt = clk_en && ctrl_reg.run_control
                      && ((ctrl_reg.counter_select && !fast_mode) ? cpin_fall : pre_hit);
    assign ovf_evt  = tick_evt && (counting_down ? (count_reg == capture_reg)
                                                 : (count_reg == CNT_MAX));
    // Trigger pin steers direction when down counting, so it cannot also reload
    assign trig_reload = clk_en && trig_fall && ctrl_reg.ext_trigger_enable && !baud_mode
                         && !ctrl_reg.capture_reload_select && !down_count_enable_reg;
    assign cap_evt     = clk_en && trig_fall && ctrl_reg.ext_trigger_enable && !baud_mode
                         && ctrl_reg.capture_reload_select;
    assign ext_set     = clk_en && trig_fall && ctrl_reg.ext_trigger_enable
                         && !toggle_mode;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_reg <= 4'h0;
        end else if (clk_en && ctrl_reg.run_control) begin
            pre_reg <= pre_hit ? 4'h0 : pre_reg + 4'h1;
        end
    end

    // ********************************
    // Control and mode registers
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= RST_BYTE;
        end else if (clk_en) begin
            if (ctrl_wr) begin
                ctrl_reg <= wr_byte;
            end
            // Hardware set wins over a same-cycle software clear
            if (ovf_evt && !baud_mode) begin
                ctrl_reg.rollover_flag <= 1'b1;
            end
            if (ovf_evt && toggle_mode) begin
                ctrl_reg.ext_event_flag <= (ctrl_wr ? wr_byte[6] : ctrl_reg.ext_event_flag)
                                           ^ 1'b1;
            end else if (ext_set) begin
                ctrl_reg.ext_event_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            down_count_enable_reg <= 1'b0;
            clock_out_enable_reg  <= 1'b0;
            tick_speed_select_reg <= 1'b0;
            irq_enable_reg        <= 1'b0;
        end else if (clk_en && wr_lane) begin
            if (wr_idx == IDX_MODE) begin
                down_count_enable_reg <= wr_byte[MODE_DOWN_BIT];
                clock_out_enable_reg  <= wr_byte[MODE_CLKOE_BIT];
            end
            if (wr_idx == IDX_AUX) begin
                tick_speed_select_reg <= wr_byte[AUX_SPEED_BIT];
                irq_enable_reg        <= wr_byte[AUX_IRQEN_BIT];
            end
        end
    end

    // ********************************
    // Count and capture
    // ********************************
    always_comb begin
        count_next = count_reg;
        if (trig_reload) begin
            count_next = capture_reg;
        end else if (ovf_evt) begin
            if (counting_down) begin
                count_next = CNT_MAX;
            end else begin
                count_next = reload_mode ? capture_reg : RST_COUNT;
            end
        end else if (tick_evt) begin
            count_next = counting_down ? count_reg - 16'h0001 : count_reg + 16'h0001;
        end
        // Software writes win over the hardware update
        if (cnt_lo_wr) begin
            count_next[7:0] = wr_byte;
        end
        if (cnt_hi_wr) begin
            count_next[15:8] = wr_byte;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_reg <= RST_COUNT;
        end else if (clk_en) begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_reg <= RST_COUNT;
        end else if (clk_en) begin
            if (cap_evt) begin
                capture_reg <= count_reg;
            end
            if (cap_lo_wr) begin
                capture_reg[7:0] <= wr_byte;
            end
            if (cap_hi_wr) begin
                capture_reg[15:8] <= wr_byte;
            end
        end
    end

    // ********************************
    // Clock output, baud ticks, interrupt
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_out_reg <= 1'b0;
            pin_oe_reg  <= 1'b0;
        end else if (clk_en) begin
            pin_oe_reg <= clkout_active;
            if (ovf_evt && clkout_active) begin
                clk_out_reg <= !clk_out_reg;
            end
        end
    end

    assign count_pin_o  = clk_out_reg;
    assign count_pin_oe = pin_oe_reg;

    logic mode13;
    assign mode13 = serial_mode[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            baud_ticks <= '0;
        end else if (clk_en) begin
            baud_ticks.rx_tick <= mode13 && (ctrl_reg.rx_baud_select ? ovf_evt
                                                                     : timer1_overflow);
            baud_ticks.tx_tick <= mode13 && (ctrl_reg.tx_baud_select ? ovf_evt
                                                                     : timer1_overflow);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq <= 1'b0;
        end else if (clk_en) begin
            timer_irq <= irq_enable_reg
                         && ((ctrl_reg.rollover_flag && !clkout_active)
                             || (ctrl_reg.ext_event_flag && !toggle_mode));
        end
    end

    // ********************************
    // Checks
    // ********************************
    a_roll_sets_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (ovf_evt && !baud_mode) |=> ctrl_reg.rollover_flag)
        else $error("rollover did not set flag");
    a_roll_flag_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        (ctrl_reg.rollover_flag && !ctrl_wr) |=> ctrl_reg.rollover_flag)
        else $error("rollover flag cleared by hardware");
    a_baud_no_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl_reg.rollover_flag && baud_mode && !ctrl_wr) |=> !ctrl_reg.rollover_flag)
        else $error("rollover flag set in baud mode");
    a_edge_sets_ext: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && trig_fall && ctrl_reg.ext_trigger_enable && !toggle_mode)
        |=> ctrl_reg.ext_event_flag)
        else $error("trigger edge did not set external flag");
    a_ext_toggles: assert property (@(posedge aclk) disable iff (!aresetn)
        (ovf_evt && toggle_mode && !ctrl_wr)
        |=> ctrl_reg.ext_event_flag != $past(ctrl_reg.ext_event_flag))
        else $error("external flag did not toggle");
    a_ext_irq: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && irq_enable_reg && ctrl_reg.ext_event_flag && !toggle_mode) |=> timer_irq)
        else $error("external flag raised no interrupt");
    a_rx_baud_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && mode13 && ctrl_reg.rx_baud_select && ovf_evt) |=> baud_ticks.rx_tick)
        else $error("receive baud tick missing");
    a_tx_baud_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        (clk_en && mode13 && !ctrl_reg.tx_baud_select && timer1_overflow)
        |=> baud_ticks.tx_tick)
        else $error("transmit baud tick missing");
    a_baud_half_rate: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick_evt && fast_mode) |=> !tick_evt)
        else $error("fast mode ticked twice in a row");
    a_halt_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
        (!ctrl_reg.run_control && !trig_reload && !cnt_lo_wr && !cnt_hi_wr)
        |=> $stable(count_reg))
        else $error("halted timer changed count");
    a_capture_count: assert property (@(posedge aclk) disable iff (!aresetn)
        (cap_evt && !cap_lo_wr && !cap_hi_wr) |=> capture_reg == $past(count_reg))
        else $error("capture did not latch count");
    a_reset_clear: assert property (@(posedge aclk)
        !aresetn |=> (count_reg == RST_COUNT) && (ctrl_reg == RST_BYTE))
        else $error("reset left state uncleared");

endmodule : scr_timer

// [scr_far.sv]
`timescale 1ns/1ps
module scr_far
    import scr_pkg::*;
(
    input  wire logic aclk,
    output logic      ext_trigger_pin,
    output wire logic count_input_pin,
    input  wire logic count_pin_o,
    input  wire logic count_pin_oe,
    output logic      timer1_overflow
);
    logic drv = 1'b1;
    initial ext_trigger_pin = 1'b1;
    initial timer1_overflow = 1'b0;
    // Pin wire: the timer owns it while its clock output is on
    assign count_input_pin = count_pin_oe ? count_pin_o : drv;

    // Low for four cycles so the synchroniser sees it
    task automatic trig_fall();
        ext_trigger_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        ext_trigger_pin <= 1'b1;
        repeat (4) @(posedge aclk);
    endtask : trig_fall

    task automatic cnt_fall(input int n);
        repeat (n) begin
            drv <= 1'b0;
            repeat (4) @(posedge aclk);
            drv <= 1'b1;
            repeat (4) @(posedge aclk);
        end
    endtask : cnt_fall

    task automatic t1_pulse();
        timer1_overflow <= 1'b1;
        @(posedge aclk);
        timer1_overflow <= 1'b0;
    endtask : t1_pulse
endmodule : scr_far

// [tb.sv]
`timescale 1ns/1ps
module tb;
    import scr_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic        awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic [1:0]  serial_mode = 2'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        trig, cpin, cpo, cpoe, t1o, timer_irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    scr_baud_t   ticks;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          n_rx = 0;
    int          n_tx = 0;
    int          cycles = 0;

    always #4 aclk = ~aclk;

    scr_timer dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_trigger_pin(trig),
        .count_input_pin(cpin), .count_pin_o(cpo), .count_pin_oe(cpoe),
        .serial_mode(serial_mode), .timer1_overflow(t1o),
        .baud_ticks(ticks), .timer_irq(timer_irq));

    scr_far far_u (.aclk(aclk), .ext_trigger_pin(trig), .count_input_pin(cpin),
        .count_pin_o(cpo), .count_pin_oe(cpoe), .timer1_overflow(t1o));

    // ********************************
    // Checking and bus tasks
    // ********************************
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [9:0] i, input logic [7:0] v, input logic [1:0] er);
        awaddr <= {i, 2'b00};
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [9:0] i, input logic [7:0] exp, input logic [1:0] er);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk(rdata, {24'h000000, exp});
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (ticks.rx_tick === 1'b1) begin
            n_rx <= n_rx + 1;
        end
        if (ticks.tx_tick === 1'b1) begin
            n_tx <= n_tx + 1;
        end
        if (cycles == 6000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ********************************
    // Tests
    // ********************************
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int k = 0; k < 7; k++) begin
            rd(IDX_CONTROL + 10'(k), 8'h00, RESP_OKAY);
        end
        rd(10'h0CF, 8'h00, RESP_SLVERR);
        wr(10'h0CF, 8'hFF, RESP_SLVERR);
        $display("test reset done");
        wr(IDX_AUX, 8'h01, RESP_OKAY);
        wr(IDX_CAP_HIGH, 8'h12, RESP_OKAY);
        wr(IDX_CNT_LOW, 8'hFE, RESP_OKAY);
        wr(IDX_CNT_HIGH, 8'hFF, RESP_OKAY);
        wr(IDX_CONTROL, 8'h04, RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(IDX_CONTROL, 8'h84, RESP_OKAY);
        rd(IDX_CNT_HIGH, 8'h12, RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(IDX_CONTROL, 8'h84, RESP_OKAY);
        wr(IDX_CONTROL, 8'h00, RESP_OKAY);
        wr(IDX_CNT_LOW, 8'h55, RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(IDX_CNT_LOW, 8'h55, RESP_OKAY);
        $display("test rollover done");
        wr(IDX_CNT_LOW, 8'hAB, RESP_OKAY);
        wr(IDX_CNT_HIGH, 8'hCD, RESP_OKAY);
        wr(IDX_CONTROL, 8'h01, RESP_OKAY);
        far_u.trig_fall();
        rd(IDX_CONTROL, 8'h01, RESP_OKAY);
        rd(IDX_CAP_HIGH, 8'h12, RESP_OKAY);
        wr(IDX_CONTROL, 8'h09, RESP_OKAY);
        far_u.trig_fall();
        rd(IDX_CONTROL, 8'h49, RESP_OKAY);
        rd(IDX_CAP_LOW, 8'hAB, RESP_OKAY);
        rd(IDX_CAP_HIGH, 8'hCD, RESP_OKAY);
        wr(IDX_AUX, 8'h02, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, timer_irq}, 32'h1);
        wr(IDX_CONTROL, 8'h09, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, timer_irq}, 32'h0);
        $display("test capture done");
        wr(IDX_CNT_LOW, 8'h11, RESP_OKAY);
        wr(IDX_CONTROL, 8'h08, RESP_OKAY);
        far_u.trig_fall();
        rd(IDX_CNT_LOW, 8'hAB, RESP_OKAY);
        rd(IDX_CONTROL, 8'h48, RESP_OKAY);
        wr(IDX_CONTROL, 8'h40, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, timer_irq}, 32'h1);
        $display("test reload done");
        wr(IDX_CNT_LOW, 8'h00, RESP_OKAY);
        wr(IDX_CONTROL, 8'h06, RESP_OKAY);
        far_u.cnt_fall(3);
        rd(IDX_CNT_LOW, 8'h03, RESP_OKAY);
        wr(IDX_CONTROL, 8'h00, RESP_OKAY);
        serial_mode <= 2'h1;
        n_rx <= 0;
        n_tx <= 0;
        far_u.t1_pulse();
        repeat (4) @(posedge aclk);
        chk(32'(n_rx), 32'h1);
        chk(32'(n_tx), 32'h1);
        $display("test counter done");
        wr(IDX_CAP_LOW, 8'hF0, RESP_OKAY);
        wr(IDX_CAP_HIGH, 8'hFF, RESP_OKAY);
        wr(IDX_CNT_LOW, 8'hF0, RESP_OKAY);
        wr(IDX_CNT_HIGH, 8'hFF, RESP_OKAY);
        n_rx <= 0;
        n_tx <= 0;
        wr(IDX_CONTROL, 8'h34, RESP_OKAY);
        // Reload every 16 ticks of 2 clocks gives 6 or 7 ticks
        repeat (200) @(posedge aclk);
        chk({31'h0, n_rx >= 5 && n_rx <= 7}, 32'h1);
        chk({31'h0, n_tx >= 5 && n_tx <= 7}, 32'h1);
        rd(IDX_CONTROL, 8'h34, RESP_OKAY);
        $display("test baud done");
        // Up counting with down enable: external flag acts as 17th bit
        wr(IDX_CONTROL, 8'h00, RESP_OKAY);
        wr(IDX_MODE, 8'h01, RESP_OKAY);
        wr(IDX_CNT_LOW, 8'hFE, RESP_OKAY);
        wr(IDX_CNT_HIGH, 8'hFF, RESP_OKAY);
        wr(IDX_CONTROL, 8'h04, RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(IDX_CONTROL, 8'hC4, RESP_OKAY);
        wr(IDX_CONTROL, 8'h44, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, timer_irq}, 32'h0);
        wr(IDX_CONTROL, 8'h00, RESP_OKAY);
        wr(IDX_MODE, 8'h02, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({31'h0, cpoe}, 32'h1);
        $display("test modes done");
        end_of_test();
    end
endmodule : tb
